// file: hdl/ulpi_pin_defines.svh
// Offsets, field positions, reset values and counts of the ULPI pin block.
// Included by bare name from the hdl files; definitions only.
`ifndef ULPI_PIN_DEFINES_SVH
`define ULPI_PIN_DEFINES_SVH

`define REG_ADDR_W        4
`define REG_DATA_W        16

`define OFS_CTRL          4'h0
`define OFS_STATUS        4'h1
`define OFS_FREQ          4'h2
`define OFS_TO_LINK       4'h3
`define OFS_FROM_LINK     4'h4

`define CTRL_VBUS_BIT     0
`define CTRL_RESET        16'h0000

`define ST_CLK_OUT_BIT    0
`define ST_FREQ_BIT       1
`define ST_SELECT_BIT     2
`define ST_RX_AVAIL_BIT   3
`define ST_TX_BUSY_BIT    4
`define ST_EDGES_LSB      8

`define PIN_REF           0
`define PIN_FREQ          1
`define PIN_SELECT        2
`define PIN_RESET         3
`define PIN_COUNT         4

`define REF_EDGES_NEEDED  3'h4
`define REF_FREQ_LOW_KHZ  16'd19200
`define REF_FREQ_HIGH_KHZ 16'd26000

`endif

// file: hdl/ulpi_pin_pkg.sv
// Types shared by the ULPI pin control block.
// No dependencies.
package ulpi_pin_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_TURN_IN,
		ST_SEND,
		ST_TURN_OUT,
		ST_LINK_TX
	} ulpi_state_e;

	typedef enum logic {
		CLK_INPUT,
		CLK_OUTPUT
	} clk_mode_e;

endpackage : ulpi_pin_pkg

// file: hdl/byte_handshake_cdc.sv
// Toggle handshake carrying one byte between two unrelated clocks.
// Each side has its own async active-low reset; data held while busy.
`timescale 1ns/1ps

module byte_handshake_cdc (
	input  wire logic       src_clk,
	input  wire logic       src_rst_n,
	input  wire logic       src_valid,
	input  wire logic [7:0] src_data,
	output      logic       src_busy,
	input  wire logic       dst_clk,
	input  wire logic       dst_rst_n,
	output      logic       dst_valid,
	output      logic [7:0] dst_data,
	input  wire logic       dst_ready
);

	logic       req_tgl_r;
	logic [7:0] hold_r;
	logic       ack_meta_r;
	logic       ack_sync_r;
	logic       req_meta_r;
	logic       req_sync_r;
	logic       req_seen_r;
	logic       ack_tgl_r;
	logic       dst_valid_r;
	logic [7:0] dst_data_r;
	logic       req_new;

	assign src_busy  = req_tgl_r ^ ack_sync_r;
	assign req_new   = req_sync_r ^ req_seen_r;
	assign dst_valid = dst_valid_r;
	assign dst_data  = dst_data_r;

	// Offer ignored while busy, so the held byte never changes mid-flight
	always_ff @(posedge src_clk or negedge src_rst_n)
	begin
		if (!src_rst_n)
		begin
			req_tgl_r  <= 1'b0;
			hold_r     <= 8'h00;
			ack_meta_r <= 1'b0;
			ack_sync_r <= 1'b0;
		end
		else
		begin
			ack_meta_r <= ack_tgl_r;
			ack_sync_r <= ack_meta_r;
			if (src_valid && !src_busy)
			begin
				req_tgl_r <= ~req_tgl_r;
				hold_r    <= src_data;
			end
		end
	end

	always_ff @(posedge dst_clk or negedge dst_rst_n)
	begin
		if (!dst_rst_n)
		begin
			req_meta_r  <= 1'b0;
			req_sync_r  <= 1'b0;
			req_seen_r  <= 1'b0;
			ack_tgl_r   <= 1'b0;
			dst_valid_r <= 1'b0;
			dst_data_r  <= 8'h00;
		end
		else
		begin
			req_meta_r <= req_tgl_r;
			req_sync_r <= req_meta_r;
			if (req_new)
			begin
				req_seen_r  <= req_sync_r;
				dst_valid_r <= 1'b1;
				dst_data_r  <= hold_r;
			end
			else if (dst_valid_r && dst_ready)
			begin
				dst_valid_r <= 1'b0;
				ack_tgl_r   <= ~ack_tgl_r;
			end
		end
	end

endmodule : byte_handshake_cdc

// file: hdl/ulpi_phy_pin_control.sv
// Pin control and ULPI bus end of a USB transceiver.
// clk_sys is 100 MHz; ulpi_clk is the clock seen on the ULPI clock pin.
`timescale 1ns/1ps
`include "ulpi_pin_defines.svh"

// Summary of operation
// - Reference frequency is 19.2 MHz with the select pin low, 26 MHz high.
// - Every ULPI transfer is synchronous to the one ULPI clock.
// - After reset the ULPI clock pin is an input, clocked by the link.
// - After 4 rising reference edges the ULPI clock pin becomes an output.
// - An active-high output switches the external VBUS supply.
// - Select low powers down and floats the ULPI bus; high runs normally.
// - Reset pin low restores all logic but the frequency register to defaults and floats the bus.
// - The device has an 8-bit two-way data bus, drives DIR and NXT, reads STP.
module ulpi_phy_pin_control (
	input  wire logic                   clk_sys,
	input  wire logic                   rst_n,
	input  wire logic                   reference_clock_in,
	input  wire logic                   freq_sel_in,
	input  wire logic                   chip_select_in,
	input  wire logic                   active_low_reset_in,
	input  wire logic [`REG_ADDR_W-1:0] reg_addr,
	input  wire logic [`REG_DATA_W-1:0] reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	output      logic [`REG_DATA_W-1:0] reg_rdata,
	output      logic                   vbus_supply_enable_out,
	input  wire logic                   ulpi_clk,
	output      logic                   ulpi_clk_out,
	output      logic                   ulpi_clk_oe,
	input  wire logic [7:0]             ulpi_data_in,
	output      logic [7:0]             ulpi_data_out,
	output      logic                   ulpi_data_oe,
	output      logic                   ulpi_dir,
	output      logic                   ulpi_nxt,
	input  wire logic                   ulpi_stp
);

	function automatic logic reg_hit(
		input logic [`REG_ADDR_W-1:0] addr,
		input logic [`REG_ADDR_W-1:0] ofs
	);
		reg_hit = (addr == ofs);
	endfunction : reg_hit

	// System clock domain

	logic [`PIN_COUNT-1:0]  pin_async;
	logic [`PIN_COUNT-1:0]  pin_meta_r;
	logic [`PIN_COUNT-1:0]  pin_sync_r;
	logic                   pin_reset_n;
	logic                   pin_select;
	logic                   freq_pin;
	logic                   ref_prev_r;
	logic                   ref_rise;
	logic [2:0]             edge_cnt_r;
	logic [2:0]             edge_cnt_nxt;
	ulpi_pin_pkg::clk_mode_e clk_mode_r;
	ulpi_pin_pkg::clk_mode_e clk_mode_nxt;
	logic                   run_r;
	logic                   clk_out_r;
	logic [`REG_DATA_W-1:0] ctrl_r;
	logic [`REG_DATA_W-1:0] freq_khz_r;
	logic [`REG_DATA_W-1:0] freq_khz_nxt;
	logic [`REG_DATA_W-1:0] status_word;
	logic [`REG_DATA_W-1:0] rdata_r;
	logic [`REG_DATA_W-1:0] rdata_nxt;
	logic                   ctrl_wr;
	logic                   to_link_wr;
	logic                   from_link_rd;
	logic                   to_link_busy;
	logic                   from_link_avail;
	logic [7:0]             from_link_byte;

	assign pin_async = {active_low_reset_in, chip_select_in,
		freq_sel_in, reference_clock_in};

	genvar gi;
	generate
		for (gi = 0; gi < `PIN_COUNT; gi++)
		begin : g_pin_sync
			always_ff @(posedge clk_sys or negedge rst_n)
			begin
				if (!rst_n)
				begin
					pin_meta_r[gi] <= 1'b0;
					pin_sync_r[gi] <= 1'b0;
				end
				else
				begin
					pin_meta_r[gi] <= pin_async[gi];
					pin_sync_r[gi] <= pin_meta_r[gi];
				end
			end
		end
	endgenerate

	assign pin_reset_n = pin_sync_r[`PIN_RESET];
	assign pin_select  = pin_sync_r[`PIN_SELECT];
	assign freq_pin    = pin_sync_r[`PIN_FREQ];
	assign ref_rise    = pin_sync_r[`PIN_REF] & ~ref_prev_r;

	// Counter saturates; a grounded reference leaves the pin an input
	assign edge_cnt_nxt = !pin_reset_n ? 3'h0 :
		(ref_rise && edge_cnt_r != `REF_EDGES_NEEDED) ?
		edge_cnt_r + 3'h1 : edge_cnt_r;
	assign clk_mode_nxt = (!pin_reset_n) ? ulpi_pin_pkg::CLK_INPUT :
		(edge_cnt_r == `REF_EDGES_NEEDED) ? ulpi_pin_pkg::CLK_OUTPUT :
		clk_mode_r;
	assign freq_khz_nxt = freq_pin ? `REF_FREQ_HIGH_KHZ :
		`REF_FREQ_LOW_KHZ;

	assign ctrl_wr      = reg_wr & reg_hit(reg_addr, `OFS_CTRL);
	assign to_link_wr   = reg_wr & reg_hit(reg_addr, `OFS_TO_LINK);
	assign from_link_rd = reg_rd & reg_hit(reg_addr, `OFS_FROM_LINK);

	always_comb
	begin
		status_word = '0;
		status_word[`ST_CLK_OUT_BIT]  = (clk_mode_r == ulpi_pin_pkg::CLK_OUTPUT);
		status_word[`ST_FREQ_BIT]     = freq_pin;
		status_word[`ST_SELECT_BIT]   = pin_select;
		status_word[`ST_RX_AVAIL_BIT] = from_link_avail;
		status_word[`ST_TX_BUSY_BIT]  = to_link_busy;
		status_word[`ST_EDGES_LSB +: 3] = edge_cnt_r;
	end

	// Unmapped addresses read zero
	assign rdata_nxt =
		!reg_rd ? '0 :
		reg_hit(reg_addr, `OFS_CTRL)      ? ctrl_r :
		reg_hit(reg_addr, `OFS_STATUS)    ? status_word :
		reg_hit(reg_addr, `OFS_FREQ)      ? freq_khz_r :
		reg_hit(reg_addr, `OFS_FROM_LINK) ? {8'h00, from_link_byte} :
		'0;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ref_prev_r <= 1'b0;
			edge_cnt_r <= 3'h0;
			clk_mode_r <= ulpi_pin_pkg::CLK_INPUT;
			freq_khz_r <= `REF_FREQ_LOW_KHZ;
			rdata_r    <= '0;
			run_r      <= 1'b0;
		end
		else
		begin
			ref_prev_r <= pin_sync_r[`PIN_REF];
			edge_cnt_r <= edge_cnt_nxt;
			clk_mode_r <= clk_mode_nxt;
			freq_khz_r <= freq_khz_nxt;
			rdata_r    <= rdata_nxt;
			run_r      <= pin_reset_n & pin_select;
		end
	end

	// Software-visible state but the frequency register returns to default while the pin is low
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			ctrl_r <= `CTRL_RESET;
		else if (!pin_reset_n)
			ctrl_r <= `CTRL_RESET;
		else if (ctrl_wr)
			ctrl_r <= reg_wdata;
	end

	// Stand-in for the internal clock source; the analog PLL is not modelled
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			clk_out_r <= 1'b0;
		else if (clk_mode_r == ulpi_pin_pkg::CLK_OUTPUT && run_r)
			clk_out_r <= ~clk_out_r;
		else
			clk_out_r <= 1'b0;
	end

	assign reg_rdata              = rdata_r;
	assign vbus_supply_enable_out = ctrl_r[`CTRL_VBUS_BIT];
	assign ulpi_clk_out           = clk_out_r;
	assign ulpi_clk_oe            =
		(clk_mode_r == ulpi_pin_pkg::CLK_OUTPUT) & run_r;

	// ULPI clock domain

	logic                     ulpi_rst_meta_r;
	logic                     ulpi_rst_n_r;
	ulpi_pin_pkg::ulpi_state_e state_r;
	ulpi_pin_pkg::ulpi_state_e state_nxt;
	logic                     dir_r;
	logic                     dir_nxt;
	logic                     nxt_r;
	logic                     nxt_nxt;
	logic [7:0]               dout_r;
	logic [7:0]               dout_nxt;
	logic                     doe_r;
	logic                     doe_nxt;
	logic                     tl_valid;
	logic [7:0]               tl_data;
	logic                     tl_take;
	logic                     fl_push;
	logic                     fl_busy;
	logic                     link_idle;

	// Held in reset while the pins say off or in reset; floats the bus
	always_ff @(posedge ulpi_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ulpi_rst_meta_r <= 1'b0;
			ulpi_rst_n_r    <= 1'b0;
		end
		else
		begin
			ulpi_rst_meta_r <= run_r;
			ulpi_rst_n_r    <= ulpi_rst_meta_r;
		end
	end

	byte_handshake_cdc u_to_link (
		.src_clk   (clk_sys),
		.src_rst_n (run_r), // Both ends reset together, no stale toggle
		.src_valid (to_link_wr),
		.src_data  (reg_wdata[7:0]),
		.src_busy  (to_link_busy),
		.dst_clk   (ulpi_clk),
		.dst_rst_n (ulpi_rst_n_r),
		.dst_valid (tl_valid),
		.dst_data  (tl_data),
		.dst_ready (tl_take)
	);

	byte_handshake_cdc u_from_link (
		.src_clk   (ulpi_clk),
		.src_rst_n (ulpi_rst_n_r),
		.src_valid (fl_push),
		.src_data  (ulpi_data_in),
		.src_busy  (fl_busy),
		.dst_clk   (clk_sys),
		.dst_rst_n (run_r), // Held byte dropped while off or in reset
		.dst_valid (from_link_avail),
		.dst_data  (from_link_byte),
		.dst_ready (from_link_rd)
	);

	assign link_idle = (ulpi_data_in == 8'h00);

	// Link-started sends win over a pending byte for the link
	always_comb
	begin
		state_nxt = state_r;
		dir_nxt   = dir_r;
		nxt_nxt   = 1'b0;
		dout_nxt  = dout_r;
		doe_nxt   = 1'b0;
		tl_take   = 1'b0;
		fl_push   = 1'b0;
		unique case (state_r)
			ulpi_pin_pkg::ST_IDLE:
				if (!link_idle)
				begin
					nxt_nxt   = !fl_busy;
					state_nxt = ulpi_pin_pkg::ST_LINK_TX;
				end
				else if (tl_valid)
				begin
					dir_nxt   = 1'b1;
					state_nxt = ulpi_pin_pkg::ST_TURN_IN;
				end
			ulpi_pin_pkg::ST_TURN_IN:
			begin
				dout_nxt  = tl_data;
				doe_nxt   = 1'b1;
				nxt_nxt   = 1'b1;
				tl_take   = 1'b1;
				state_nxt = ulpi_pin_pkg::ST_SEND;
			end
			ulpi_pin_pkg::ST_SEND:
			begin
				dir_nxt   = 1'b0;
				state_nxt = ulpi_pin_pkg::ST_TURN_OUT;
			end
			ulpi_pin_pkg::ST_TURN_OUT:
				state_nxt = ulpi_pin_pkg::ST_IDLE;
			ulpi_pin_pkg::ST_LINK_TX:
				if (ulpi_stp)
					state_nxt = ulpi_pin_pkg::ST_IDLE;
				else
				begin
					// One byte per crossing; NXT throttles the link meanwhile
					fl_push = nxt_r;
					nxt_nxt = !fl_busy && !nxt_r;
				end
		endcase
	end

	always_ff @(posedge ulpi_clk or negedge ulpi_rst_n_r)
	begin
		if (!ulpi_rst_n_r)
		begin
			state_r <= ulpi_pin_pkg::ST_IDLE;
			dir_r   <= 1'b0;
			nxt_r   <= 1'b0;
			dout_r  <= 8'h00;
			doe_r   <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			dir_r   <= dir_nxt;
			nxt_r   <= nxt_nxt;
			dout_r  <= dout_nxt;
			doe_r   <= doe_nxt;
		end
	end

	assign ulpi_dir      = dir_r;
	assign ulpi_nxt      = nxt_r;
	assign ulpi_data_out = dout_r;
	assign ulpi_data_oe  = doe_r & dir_r;

	// Checks

	a_freq_select: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		1'b1 |=> freq_khz_r == ($past(freq_pin) ?
			`REF_FREQ_HIGH_KHZ : `REF_FREQ_LOW_KHZ))
		else $error("reference frequency does not follow select pin");

	a_clk_input_default: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		edge_cnt_r != `REF_EDGES_NEEDED |-> ##1 !ulpi_clk_oe ||
			$past(clk_mode_r) == ulpi_pin_pkg::CLK_OUTPUT)
		else $error("clock pin driven before four reference edges");

	a_clk_switch_out: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		pin_reset_n && ref_rise && edge_cnt_r == 3'h3 ##1 pin_reset_n
		|=> clk_mode_r == ulpi_pin_pkg::CLK_OUTPUT)
		else $error("clock pin not switched after fourth edge");

	a_vbus_follow: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		ctrl_wr && pin_reset_n |=>
			vbus_supply_enable_out == $past(reg_wdata[`CTRL_VBUS_BIT]))
		else $error("vbus enable does not follow write");

	a_reset_defaults: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		!pin_reset_n |=> ctrl_r == `CTRL_RESET && edge_cnt_r == 3'h0 ##1
			clk_mode_r == ulpi_pin_pkg::CLK_INPUT)
		else $error("reset pin does not restore defaults");

	a_off_bus_float: assert property (
		@(posedge ulpi_clk) disable iff (!rst_n)
		!ulpi_rst_n_r |-> !ulpi_data_oe && !ulpi_dir && !ulpi_nxt)
		else $error("ulpi bus driven while off or in reset");

	a_data_with_dir: assert property (
		@(posedge ulpi_clk) disable iff (!ulpi_rst_n_r)
		ulpi_data_oe |-> ulpi_dir && $past(ulpi_dir))
		else $error("data driven without dir or turnaround");

	a_dir_turnaround: assert property (
		@(posedge ulpi_clk) disable iff (!ulpi_rst_n_r)
		$rose(ulpi_dir) |-> !ulpi_data_oe ##1 ulpi_data_oe ##1
			!ulpi_dir ##1 state_r == ulpi_pin_pkg::ST_IDLE)
		else $error("missing turnaround around dir change");

	a_stp_ends_tx: assert property (
		@(posedge ulpi_clk) disable iff (!ulpi_rst_n_r)
		state_r == ulpi_pin_pkg::ST_LINK_TX && ulpi_stp |=>
			!ulpi_nxt && state_r == ulpi_pin_pkg::ST_IDLE)
		else $error("stp does not end the link send");

endmodule : ulpi_phy_pin_control

// file: verification/ulpi_link_model.sv
// Behavioural USB link controller at the far end of the ULPI bus.
// Assumes ulpi_clk runs free; the bench calls link_send for link traffic.
`timescale 1ns/1ps

module ulpi_link_model (
	input  wire logic       ulpi_clk,
	input  wire logic       ulpi_dir,
	input  wire logic       ulpi_nxt,
	input  wire logic [7:0] ulpi_data_out,
	input  wire logic       ulpi_data_oe,
	output      logic [7:0] ulpi_data_in,
	output      logic       ulpi_stp,
	output      logic [7:0] got_byte,
	output      logic [7:0] got_count
);
	logic [7:0] link_data_r = 8'h00;
	logic [7:0] last_r      = 8'h00;
	logic [7:0] got_r       = 8'h00;
	logic [7:0] cnt_r       = 8'h00;
	logic       turn_r      = 1'b0;
	logic       stp_r       = 1'b0;
	logic       link_drive;

	// Off the bus while dir is high and for the turnaround after it
	assign link_drive = !ulpi_dir && !turn_r;
	// Floating bus shows a changing value so no float reads as clean
	assign ulpi_data_in = ulpi_data_oe ? ulpi_data_out :
		(link_drive ? link_data_r : ~last_r);
	assign ulpi_stp  = stp_r;
	assign got_byte  = got_r;
	assign got_count = cnt_r;

	always @(posedge ulpi_clk)
	begin
		turn_r <= ulpi_dir;
		last_r <= ulpi_data_in;
		if (ulpi_dir && ulpi_data_oe)
		begin
			got_r <= ulpi_data_out;
			cnt_r <= cnt_r + 8'h01;
		end
	end

	// Command held until nxt is seen at an edge or 60 edges pass, then stp ends the send
	task automatic link_send(input logic [7:0] cmd, output logic ok);
		int n;
		ok = 1'b0;
		@(posedge ulpi_clk);
		link_data_r <= cmd;
		for (n = 0; n < 60 && !ok; n++)
		begin
			@(posedge ulpi_clk);
			ok = ulpi_nxt;
		end
		stp_r <= 1'b1;
		link_data_r <= 8'h00;
		@(posedge ulpi_clk);
		stp_r <= 1'b0;
	endtask : link_send

endmodule : ulpi_link_model

// file: verification/tb_ulpi_phy_pin_control.sv
// Self-checking bench for the ULPI pin control block.
// Assumes the hdl files and ulpi_link_model are compiled first.
`timescale 1ns/1ps
`include "ulpi_pin_defines.svh"

module tb_ulpi_phy_pin_control;
	logic        clk_sys = 1'b0;
	logic        ulpi_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        reference_clock_in, freq_sel_in;
	logic        chip_select_in, active_low_reset_in;
	logic        reg_wr, reg_rd, vbus_supply_enable_out;
	logic        ulpi_clk_out, ulpi_clk_oe, ulpi_data_oe;
	logic        ulpi_dir, ulpi_nxt, ulpi_stp, ok, t;
	logic [3:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata, v;
	logic [7:0]  ulpi_data_in, ulpi_data_out, got_byte, got_count, n0;
	int          err_count = 0;
	int          checked = 0;
	int          k;

	localparam logic [15:0] m_clk  = 16'h0001 << `ST_CLK_OUT_BIT;
	localparam logic [15:0] m_freq = 16'h0001 << `ST_FREQ_BIT;
	localparam logic [15:0] m_sel  = 16'h0001 << `ST_SELECT_BIT;
	localparam logic [15:0] m_rx   = 16'h0001 << `ST_RX_AVAIL_BIT;
	localparam logic [15:0] m_edge = 16'h0007 << `ST_EDGES_LSB;
	localparam logic [15:0] m_vbus = 16'h0001 << `CTRL_VBUS_BIT;
	localparam logic [7:0]  tx_bytes [3] = '{8'ha5, 8'h00, 8'hff};
	localparam logic [7:0]  rx_cmds [2]  = '{8'h41, 8'hc3};

	always #5 clk_sys = ~clk_sys;
	// Link clock offset so its edges never line up with clk_sys
	initial
	begin
		#1.7;
		forever #3 ulpi_clk = ~ulpi_clk;
	end

	ulpi_phy_pin_control dut_u (.clk_sys, .rst_n, .reference_clock_in,
		.freq_sel_in, .chip_select_in, .active_low_reset_in, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .vbus_supply_enable_out,
		.ulpi_clk, .ulpi_clk_out, .ulpi_clk_oe, .ulpi_data_in, .ulpi_data_out,
		.ulpi_data_oe, .ulpi_dir, .ulpi_nxt, .ulpi_stp);

	ulpi_link_model link_u (.ulpi_clk, .ulpi_dir, .ulpi_nxt, .ulpi_data_out,
		.ulpi_data_oe, .ulpi_data_in, .ulpi_stp, .got_byte, .got_count);

	task automatic chk(input string what, input logic [15:0] seen, exp);
		checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : cyc

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data stands only in the cycle after the strobe
	task automatic rchk(input string what, input logic [3:0] a,
		input logic [15:0] mask, exp);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
		chk(what, v & mask, exp);
	endtask : rchk

	// Each level held well past the two-flop pin sync
	task automatic ref_edges(input int n);
		repeat (n)
		begin
			@(posedge clk_sys);
			reference_clock_in <= 1'b1;
			cyc(4);
			@(posedge clk_sys);
			reference_clock_in <= 1'b0;
			cyc(4);
		end
	endtask : ref_edges

	task automatic close_out;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : close_out

	initial
	begin
		#200000;
		err_count++;
		$display("watchdog expired");
		close_out();
	end

	initial
	begin
		reference_clock_in = 1'b0;
		freq_sel_in = 1'b0;
		chip_select_in = 1'b1;
		active_low_reset_in = 1'b1;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		cyc(8);
		rchk("ctrl", `OFS_CTRL, 16'hffff, `CTRL_RESET);
		rchk("status", `OFS_STATUS, m_clk|m_freq|m_sel|m_edge, m_sel);
		chk("clk_oe", ulpi_clk_oe, 16'h0000);
		chk("vbus", vbus_supply_enable_out, 16'h0000);
		$display("test reset done");

		rchk("freq lo", `OFS_FREQ, 16'hffff, `REF_FREQ_LOW_KHZ);
		@(posedge clk_sys);
		freq_sel_in <= 1'b1;
		cyc(4);
		wr(`OFS_FREQ, 16'h0000);
		rchk("freq hi", `OFS_FREQ, 16'hffff, `REF_FREQ_HIGH_KHZ);
		rchk("freq pin", `OFS_STATUS, m_freq, m_freq);
		rchk("unmapped", 4'hf, 16'hffff, 16'h0000);
		$display("test frequency done");

		wr(`OFS_CTRL, m_vbus);
		cyc(1);
		chk("vbus on", vbus_supply_enable_out, 16'h0001);
		wr(`OFS_CTRL, 16'h0000);
		cyc(1);
		chk("vbus off", vbus_supply_enable_out, 16'h0000);
		wr(`OFS_CTRL, m_vbus);
		$display("test vbus done");

		ref_edges(3);
		cyc(6);
		rchk("edges 3", `OFS_STATUS, m_clk|m_edge, 16'(3) << `ST_EDGES_LSB);
		chk("clk_oe 3", ulpi_clk_oe, 16'h0000);
		ref_edges(1);
		cyc(6);
		rchk("edges 4", `OFS_STATUS, m_clk|m_edge,
			m_clk | (16'(4) << `ST_EDGES_LSB));
		chk("clk_oe 4", ulpi_clk_oe, 16'h0001);
		t = ulpi_clk_out;
		cyc(1);
		chk("clk_out", ulpi_clk_out, !t);
		ref_edges(1);
		cyc(6);
		rchk("edges sat", `OFS_STATUS, m_edge, 16'(4) << `ST_EDGES_LSB);
		$display("test clock pin done");

		foreach (tx_bytes[i])
		begin
			n0 = got_count;
			wr(`OFS_TO_LINK, {8'h00, tx_bytes[i]});
			// Refused while the first byte is still in flight
			wr(`OFS_TO_LINK, 16'h005a);
			cyc(100);
			chk("tx count", got_count - n0, 16'h0001);
			chk("tx byte", got_byte, tx_bytes[i]);
		end
		$display("test device send done");

		foreach (rx_cmds[i])
		begin
			link_u.link_send(rx_cmds[i], ok);
			chk("nxt seen", ok, 16'h0001);
			cyc(10);
			rchk("rx avail", `OFS_STATUS, m_rx, m_rx);
			rchk("rx byte", `OFS_FROM_LINK, 16'h00ff, rx_cmds[i]);
			rchk("rx popped", `OFS_STATUS, m_rx, 16'h0000);
		end
		$display("test link send done");
		// Leave one byte held across power down
		link_u.link_send(8'h7e, ok);
		cyc(10);

		@(posedge clk_sys);
		chip_select_in <= 1'b0;
		cyc(10);
		chk("sel dir", ulpi_dir, 16'h0000);
		chk("sel data_oe", ulpi_data_oe, 16'h0000);
		chk("sel clk_oe", ulpi_clk_oe, 16'h0000);
		rchk("sel ctrl", `OFS_CTRL, 16'hffff, m_vbus);
		@(posedge clk_sys);
		chip_select_in <= 1'b1;
		cyc(10);
		chk("sel back", ulpi_clk_oe, 16'h0001);
		rchk("sel rx drop", `OFS_STATUS, m_rx, 16'h0000);
		link_u.link_send(8'h3c, ok);
		chk("sel nxt", ok, 16'h0001);
		$display("test select done");

		@(posedge clk_sys);
		active_low_reset_in <= 1'b0;
		cyc(10);
		chk("rst vbus", vbus_supply_enable_out, 16'h0000);
		chk("rst data_oe", ulpi_data_oe, 16'h0000);
		chk("rst clk_oe", ulpi_clk_oe, 16'h0000);
		wr(`OFS_CTRL, m_vbus);
		rchk("rst ctrl", `OFS_CTRL, 16'hffff, 16'h0000);
		rchk("rst status", `OFS_STATUS, m_clk|m_edge, 16'h0000);
		@(posedge clk_sys);
		active_low_reset_in <= 1'b1;
		cyc(10);
		chk("rst input mode", ulpi_clk_oe, 16'h0000);
		$display("test reset pin done");
		close_out();
	end

endmodule : tb_ulpi_phy_pin_control
